// [shared/bmsm_pkg.sv]
// Behaviour
// RULE1 - Sleep part of sample-sleep powers analog off; each interval does one conversion set.
// RULE2 - Sleep interval is timed by a separate low-power timebase; primary oscillator may stop.
// RULE3 - Enter sample-sleep when an enabled cell voltage falls below the cell trip threshold.
// RULE4 - No sample-sleep entry while charge wake is enabled and current exceeds positive trip.
// RULE5 - Software sets the sample-sleep request bit; the device then enters sample-sleep.
// RULE6 - Enter sample-sleep when enabled and current is below the negative current trip.
// RULE7 - Wake interval is 2^sample divider times 2^sleep divider times half a second.
// RULE8 - Leave sample-sleep to run when the request bit clears or an enabled wake occurs.
// RULE9 - Charge wake enabled and current above positive trip wakes sample-sleep into run.
// RULE10 - Pack wake enabled and pack voltage above sleep wake threshold wakes into run.
// RULE11 - Shelf-sleep: no measurement, no accumulation, bus ignored, volatile state may be lost.
// RULE12 - Shelf entry is armed by the shelf entry bit or pack voltage below its threshold.
// RULE13 - Armed shelf entry needs both bus lines falling low and staying low for entry time.
// RULE14 - Shelf exit needs both bus lines rising high and staying high for the wake time.
// RULE15 - Run does continuous conversions; run is entered after power-on above the threshold.
// RULE16 - Sample divider gives base interval 2^value half seconds, eight settings 0.5 to 64 s.
// RULE17 - Bus line low and high durations are counted on the low-power timebase.
// RULE18 - Shelf exit reinitialises all volatile registers to reset values before running.
package bmsm_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned LP_OSC_HZ    = 32_768;
  localparam int unsigned LP_DIV_CYC   = CLK_HZ / LP_OSC_HZ;
  localparam int unsigned HALF_SEC_MS  = 500;
  localparam int unsigned HALF_SEC_LP  = (LP_OSC_HZ * HALF_SEC_MS) / 1000;
  localparam int unsigned T_SHELF_MS   = 10;
  localparam int unsigned T_SHELF_LP   = (T_SHELF_MS * LP_OSC_HZ + 999) / 1000;
  localparam int unsigned T_WAKE_MS    = 10;
  localparam int unsigned T_WAKE_LP    = (T_WAKE_MS * LP_OSC_HZ + 999) / 1000;
  localparam logic [15:0] POR_LEVEL_DEF = 16'h0800;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ADDR_OPERATING_MODE_REG   = 8'h00;
  localparam logic [7:0] ADDR_ADCCFG   = 8'h01;
  localparam logic [7:0] ADDR_TRIP_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_CELLTRIP = 8'h03;
  localparam logic [7:0] ADDR_SLEEP_WAKE_VOLTAGE_THRESHOLD   = 8'h04;
  localparam logic [7:0] ADDR_PACK_VOLTAGE_THRESHOLD   = 8'h05;
  localparam logic [7:0] ADDR_IPOS     = 8'h06;
  localparam logic [7:0] ADDR_INEG     = 8'h07;
  localparam logic [7:0] ADDR_MODE     = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ST   = 8'h09;
  localparam logic [7:0] ADDR_IRQ_CLR  = 8'h0A;
  localparam logic [7:0] ADDR_IRQ_EN   = 8'h0B;

  // ==========================================================================
  // Field positions
  localparam int OPM_SAMPLE_SLEEP_REQUEST_BIT = 0;
  localparam int OPM_SDIV_LSB = 1;
  localparam int ADC_SAMP_LSB = 0;
  localparam int TRIP_C1_BIT  = 0;
  localparam int TRIP_C2_BIT  = 1;
  localparam int TRIP_IENT    = 2;
  localparam int TRIP_IEX     = 3;
  localparam int TRIP_PACK_VOLTAGE_WAKE_ENABLE    = 4;
  localparam int TRIP_SHELF_ENTRY_ENABLE   = 5;
  localparam int IRQ_ENTRY    = 0;
  localparam int IRQ_WAKE     = 1;
  localparam int IRQ_SHELF    = 2;

  // ==========================================================================
  // Reset values
  localparam logic [2:0]  RST_DIV    = 3'h0;
  localparam logic [5:0]  RST_TRIP   = 6'h00;
  localparam logic [15:0] RST_THRESH = 16'h0000;
  localparam logic [2:0]  RST_IRQ    = 3'h0;

  typedef enum logic [2:0] {ST_POR, ST_RUN, ST_SS_SLEEP, ST_SS_ACTIVE, ST_SHELF} bmsm_state_t;

  // Wake interval in half-second ticks
  function automatic logic [14:0] ss_interval(input logic [2:0] samp, input logic [2:0] slp);
    ss_interval = 15'h0001 << ({1'b0, samp} + {1'b0, slp});
  endfunction : ss_interval

endpackage : bmsm_pkg

// [shared/bmsm_lp_if.sv]
`timescale 1ns/1ps
interface bmsm_lp_if;
  logic arm_low;
  logic in_shelf;
  logic tick;
  logic low_done;
  logic high_done;
  modport ctl (output arm_low, output in_shelf, input tick, input low_done, input high_done);
  modport lp  (input arm_low, input in_shelf, output tick, output low_done, output high_done);
endinterface : bmsm_lp_if

// [src/bmsm_lp_timer.sv]
`timescale 1ns/1ps
module bmsm_lp_timer #(
  parameter int unsigned LP_DIV   = bmsm_pkg::LP_DIV_CYC,
  parameter int unsigned HALF_LP  = bmsm_pkg::HALF_SEC_LP,
  parameter int unsigned SHELF_LP = bmsm_pkg::T_SHELF_LP,
  parameter int unsigned WAKE_LP  = bmsm_pkg::T_WAKE_LP
) (
  input  wire logic clk_sys,   // System clock
  input  wire logic resetn,    // Async reset, active low
  input  wire logic scl_i,     // Bus clock line level
  input  wire logic sda_i,     // Bus data line level
  bmsm_lp_if.lp     lp         // Timebase and line timing
);

  typedef struct packed {
    logic [15:0] div;
    logic [15:0] half;
    logic [15:0] dur;
    logic        lp_tick;
    logic        seen_high;
    logic        tick;
    logic        low_done;
    logic        high_done;
  } bmsm_lp_st_t;

  bmsm_lp_st_t r_q;
  bmsm_lp_st_t r_d;
  logic        both_low;
  logic        both_high;

  assign both_low  = !scl_i && !sda_i;
  assign both_high = scl_i && sda_i;

  // ==========================================================================
  // Low-power timebase and line duration counters
  always_comb begin
    r_d         = r_q;
    r_d.lp_tick = 1'b0;
    r_d.tick    = 1'b0;
    if (r_q.div >= 16'(LP_DIV - 1)) begin
      r_d.div     = '0;
      r_d.lp_tick = 1'b1;
    end else begin
      r_d.div = r_q.div + 16'h0001;
    end
    if (r_q.lp_tick) begin  // RULE2
      if (r_q.half >= 16'(HALF_LP - 1)) begin
        r_d.half = '0;
        r_d.tick = 1'b1;
      end else begin
        r_d.half = r_q.half + 16'h0001;
      end
    end
    if (lp.in_shelf) begin
      r_d.low_done = 1'b0;
      if (!both_high) begin  // RULE14
        r_d.dur       = '0;
        r_d.high_done = 1'b0;
      end else if (r_q.lp_tick && !r_q.high_done) begin  // RULE17
        r_d.dur       = r_q.dur + 16'h0001;
        r_d.high_done = (r_q.dur + 16'h0001) >= 16'(WAKE_LP);
      end
    end else begin
      r_d.high_done = 1'b0;
      if (both_high || !lp.arm_low) begin  // RULE13
        r_d.seen_high = both_high;
        r_d.dur       = '0;
        r_d.low_done  = 1'b0;
      end else if (!both_low) begin
        r_d.dur      = '0;
        r_d.low_done = 1'b0;
      end else if (r_q.seen_high && r_q.lp_tick && !r_q.low_done) begin  // RULE17
        r_d.dur      = r_q.dur + 16'h0001;
        r_d.low_done = (r_q.dur + 16'h0001) >= 16'(SHELF_LP);
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign lp.tick      = r_q.tick;
  assign lp.low_done  = r_q.low_done;
  assign lp.high_done = r_q.high_done;

endmodule : bmsm_lp_timer

// [src/bmsm_sleep_ctrl.sv]
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module bmsm_sleep_ctrl #(
  parameter int unsigned LP_DIV    = bmsm_pkg::LP_DIV_CYC,
  parameter int unsigned HALF_LP   = bmsm_pkg::HALF_SEC_LP,
  parameter int unsigned SHELF_LP  = bmsm_pkg::T_SHELF_LP,
  parameter int unsigned WAKE_LP   = bmsm_pkg::T_WAKE_LP,
  parameter logic [15:0] POR_LEVEL = bmsm_pkg::POR_LEVEL_DEF
) (
  input  wire logic               clk_sys,             // System clock
  input  wire logic               resetn,              // Async reset, active low
  input  wire logic [7:0]         addr_i,              // Register address
  input  wire logic [15:0]        wdata_i,             // Write data
  input  wire logic               wr_i,                // Write strobe
  input  wire logic               rd_i,                // Read strobe
  output logic      [15:0]        rdata_o,             // Read data, cycle after strobe
  input  wire logic [15:0]        first_cell_input,    // Cell 1 voltage result
  input  wire logic [15:0]        second_cell_input,   // Cell 2 voltage result
  input  wire logic [15:0]        pack_voltage,        // Pack voltage result
  input  wire logic signed [15:0] current_i,           // Current result, charge positive
  input  wire logic               conv_done_i,         // Conversion set finished
  input  wire logic               scl_i,               // Bus clock line level
  input  wire logic               sda_i,               // Bus data line level
  output logic                    conv_start_o,        // Start one conversion set
  output logic                    analog_on_o,         // Analog power enable
  output logic                    primary_osc_on_o,    // Primary oscillator enable
  output logic                    accum_en_o,          // Accumulation allowed
  output logic                    bus_en_o,            // Serial bus slave enabled
  output logic      [2:0]         mode_o,              // Current power state
  output logic                    irq_o                // Level interrupt
);

  typedef struct packed {
    bmsm_pkg::bmsm_state_t st;
    logic                  sample_sleep_request;
    logic [2:0]            sleep_div;
    logic [2:0]            samp_div;
    logic [5:0]            trip;
    logic [15:0]           cell_trip;
    logic [15:0]           ss_trip;
    logic [15:0]           vp_trip;
    logic [15:0]           ipos;
    logic [15:0]           ineg;
    logic [2:0]            irq_st;
    logic [2:0]            irq_en;
    logic [15:0]           rdata;
    logic                  by_sample_sleep_request;
    logic [14:0]           slp_cnt;
    logic                  conv_start;
    logic                  conv_busy;
    logic                  ana_on;
    logic                  osc_on;
    logic                  bus_en;
    logic                  irq;
  } bmsm_ctl_t;

  function automatic bmsm_ctl_t rst_val();
    bmsm_ctl_t v;
    v           = '0;
    v.st        = bmsm_pkg::ST_POR;
    v.sleep_div = bmsm_pkg::RST_DIV;
    v.samp_div  = bmsm_pkg::RST_DIV;
    v.trip      = bmsm_pkg::RST_TRIP;
    v.cell_trip = bmsm_pkg::RST_THRESH;
    v.ss_trip   = bmsm_pkg::RST_THRESH;
    v.vp_trip   = bmsm_pkg::RST_THRESH;
    v.ipos      = bmsm_pkg::RST_THRESH;
    v.ineg      = bmsm_pkg::RST_THRESH;
    v.irq_st    = bmsm_pkg::RST_IRQ;
    v.irq_en    = bmsm_pkg::RST_IRQ;
    return v;
  endfunction : rst_val

  bmsm_ctl_t   r_q;
  bmsm_ctl_t   r_d;
  bmsm_lp_if   lp ();
  logic        cell_low;
  logic        chg_hi;
  logic        dis_lo;
  logic        suppress;
  logic        armed;
  logic        vp_wake;
  logic        shelf_go;
  logic        sample_sleep_request_gone;
  logic [2:0]  ev;
  logic [14:0] intv;

  bmsm_lp_timer #(
    .LP_DIV   (LP_DIV),
    .HALF_LP  (HALF_LP),
    .SHELF_LP (SHELF_LP),
    .WAKE_LP  (WAKE_LP)
  ) u_lp (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .scl_i   (scl_i),
    .sda_i   (sda_i),
    .lp      (lp.lp)
  );

  // ==========================================================================
  // Trip comparisons
  assign cell_low  = (r_q.trip[bmsm_pkg::TRIP_C1_BIT] && first_cell_input < r_q.cell_trip)
                  || (r_q.trip[bmsm_pkg::TRIP_C2_BIT] && second_cell_input < r_q.cell_trip);
  assign chg_hi    = current_i > $signed(r_q.ipos);
  assign dis_lo    = r_q.trip[bmsm_pkg::TRIP_IENT] && (current_i < $signed(r_q.ineg));
  assign suppress  = r_q.trip[bmsm_pkg::TRIP_IEX] && chg_hi;
  assign vp_wake   = r_q.trip[bmsm_pkg::TRIP_PACK_VOLTAGE_WAKE_ENABLE] && (pack_voltage > r_q.ss_trip);
  assign armed     = r_q.trip[bmsm_pkg::TRIP_SHELF_ENTRY_ENABLE] || (pack_voltage < r_q.vp_trip);
  assign shelf_go  = armed && lp.low_done;
  assign sample_sleep_request_gone = r_q.by_sample_sleep_request && !r_q.sample_sleep_request;
  assign intv      = bmsm_pkg::ss_interval(r_q.samp_div, r_q.sleep_div);

  assign lp.arm_low  = armed && (r_q.st == bmsm_pkg::ST_RUN || r_q.st == bmsm_pkg::ST_SS_SLEEP);  // RULE12
  assign lp.in_shelf = (r_q.st == bmsm_pkg::ST_SHELF);

  function automatic logic [15:0] rd_mux(input bmsm_ctl_t s, input logic [7:0] a);
    logic [15:0] v;
    v = '0;
    unique case (a)
      bmsm_pkg::ADDR_OPERATING_MODE_REG:   v = {12'h000, s.sleep_div, s.sample_sleep_request};
      bmsm_pkg::ADDR_ADCCFG:   v = {13'h0, s.samp_div};
      bmsm_pkg::ADDR_TRIP_CONTROL: v = {10'h0, s.trip};
      bmsm_pkg::ADDR_CELLTRIP: v = s.cell_trip;
      bmsm_pkg::ADDR_SLEEP_WAKE_VOLTAGE_THRESHOLD:   v = s.ss_trip;
      bmsm_pkg::ADDR_PACK_VOLTAGE_THRESHOLD:   v = s.vp_trip;
      bmsm_pkg::ADDR_IPOS:     v = s.ipos;
      bmsm_pkg::ADDR_INEG:     v = s.ineg;
      bmsm_pkg::ADDR_MODE:     v = {13'h0, s.st};
      bmsm_pkg::ADDR_IRQ_ST:   v = {13'h0, s.irq_st};
      bmsm_pkg::ADDR_IRQ_EN:   v = {13'h0, s.irq_en};
      default:                 v = '0;
    endcase
    return v;
  endfunction : rd_mux

  // ==========================================================================
  // Next state
  always_comb begin
    r_d            = r_q;
    ev             = '0;
    r_d.conv_start = 1'b0;
    r_d.rdata      = (rd_i && r_q.bus_en) ? rd_mux(r_q, addr_i) : '0;
    if (conv_done_i) begin
      r_d.conv_busy = 1'b0;
    end
    if (wr_i && r_q.bus_en) begin  // RULE11
      unique case (addr_i)
        bmsm_pkg::ADDR_OPERATING_MODE_REG: begin
          r_d.sample_sleep_request      = wdata_i[bmsm_pkg::OPM_SAMPLE_SLEEP_REQUEST_BIT];
          r_d.sleep_div = wdata_i[bmsm_pkg::OPM_SDIV_LSB +: 3];
        end
        bmsm_pkg::ADDR_ADCCFG:   r_d.samp_div  = wdata_i[bmsm_pkg::ADC_SAMP_LSB +: 3];
        bmsm_pkg::ADDR_TRIP_CONTROL: r_d.trip      = wdata_i[5:0];
        bmsm_pkg::ADDR_CELLTRIP: r_d.cell_trip = wdata_i;
        bmsm_pkg::ADDR_SLEEP_WAKE_VOLTAGE_THRESHOLD:   r_d.ss_trip   = wdata_i;
        bmsm_pkg::ADDR_PACK_VOLTAGE_THRESHOLD:   r_d.vp_trip   = wdata_i;
        bmsm_pkg::ADDR_IPOS:     r_d.ipos      = wdata_i;
        bmsm_pkg::ADDR_INEG:     r_d.ineg      = wdata_i;
        bmsm_pkg::ADDR_IRQ_CLR:  r_d.irq_st    = r_q.irq_st & ~wdata_i[2:0];
        bmsm_pkg::ADDR_IRQ_EN:   r_d.irq_en    = wdata_i[2:0];
        default: ;
      endcase
    end
    unique case (r_q.st)
      bmsm_pkg::ST_POR: begin
        if (pack_voltage > POR_LEVEL) begin  // RULE15
          r_d.st = bmsm_pkg::ST_RUN;
        end
      end
      bmsm_pkg::ST_RUN: begin
        if (shelf_go) begin  // RULE13
          r_d.st          = bmsm_pkg::ST_SHELF;
          ev[bmsm_pkg::IRQ_SHELF] = 1'b1;
        end else if ((r_q.sample_sleep_request || (conv_done_i && (cell_low || dis_lo))) && !suppress) begin  // RULE3 RULE4 RULE5 RULE6
          r_d.st          = bmsm_pkg::ST_SS_SLEEP;
          r_d.by_sample_sleep_request     = r_q.sample_sleep_request;
          r_d.slp_cnt     = intv;  // RULE7 RULE16
          ev[bmsm_pkg::IRQ_ENTRY] = 1'b1;
        end else if (!r_q.conv_busy || conv_done_i) begin  // RULE15
          r_d.conv_start  = 1'b1;
          r_d.conv_busy   = 1'b1;
        end
      end
      bmsm_pkg::ST_SS_SLEEP: begin
        if (shelf_go) begin  // RULE13
          r_d.st          = bmsm_pkg::ST_SHELF;
          ev[bmsm_pkg::IRQ_SHELF] = 1'b1;
        end else if (sample_sleep_request_gone) begin  // RULE8
          r_d.st          = bmsm_pkg::ST_RUN;
          ev[bmsm_pkg::IRQ_WAKE] = 1'b1;
        end else if (lp.tick) begin  // RULE2
          if (r_q.slp_cnt <= 15'h0001) begin  // RULE1
            r_d.st         = bmsm_pkg::ST_SS_ACTIVE;
            r_d.conv_start = 1'b1;
            r_d.conv_busy  = 1'b1;
          end else begin
            r_d.slp_cnt    = r_q.slp_cnt - 15'h0001;
          end
        end
      end
      bmsm_pkg::ST_SS_ACTIVE: begin
        if (sample_sleep_request_gone) begin  // RULE8
          r_d.st          = bmsm_pkg::ST_RUN;
          ev[bmsm_pkg::IRQ_WAKE] = 1'b1;
        end else if (conv_done_i) begin
          if ((r_q.trip[bmsm_pkg::TRIP_IEX] && chg_hi) || vp_wake) begin  // RULE9 RULE10
            r_d.st        = bmsm_pkg::ST_RUN;
            ev[bmsm_pkg::IRQ_WAKE] = 1'b1;
          end else begin  // RULE1
            r_d.st        = bmsm_pkg::ST_SS_SLEEP;
            r_d.slp_cnt   = intv;
          end
        end
      end
      bmsm_pkg::ST_SHELF: begin
        if (lp.high_done) begin  // RULE14
          r_d    = rst_val();  // RULE18
          r_d.st = bmsm_pkg::ST_RUN;
        end
      end
      default: r_d.st = bmsm_pkg::ST_POR;
    endcase
    r_d.irq_st = r_d.irq_st | ev;
    r_d.ana_on = (r_d.st == bmsm_pkg::ST_RUN) || (r_d.st == bmsm_pkg::ST_SS_ACTIVE);  // RULE1
    r_d.osc_on = r_d.ana_on;  // RULE2
    r_d.bus_en = (r_d.st != bmsm_pkg::ST_SHELF) && (r_d.st != bmsm_pkg::ST_POR);  // RULE11
    r_d.irq    = |(r_d.irq_st & r_d.irq_en);
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      r_q <= rst_val();
    end else begin
      r_q <= r_d;
    end
  end

  assign rdata_o          = r_q.rdata;
  assign conv_start_o     = r_q.conv_start;
  assign analog_on_o      = r_q.ana_on;
  assign primary_osc_on_o = r_q.osc_on;
  assign accum_en_o       = r_q.ana_on;
  assign bus_en_o         = r_q.bus_en;
  assign mode_o           = r_q.st;
  assign irq_o            = r_q.irq;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_in_sleep;
    r_q.st == bmsm_pkg::ST_SS_SLEEP;
  endsequence
  sequence s_tick_expire;
    lp.tick && r_q.slp_cnt <= 15'h0001 && !shelf_go && !sample_sleep_request_gone;
  endsequence

  property p_sleep_dark;
    s_in_sleep |-> !analog_on_o && !primary_osc_on_o && !accum_en_o;
  endproperty
  a_sleep_dark: assert property (p_sleep_dark) else $error("analog on while asleep"); // RULE1

  property p_one_set;
    s_in_sleep ##0 s_tick_expire |=> conv_start_o && r_q.st == bmsm_pkg::ST_SS_ACTIVE ##1 !conv_start_o;
  endproperty
  a_one_set: assert property (p_one_set) else $error("wake did not start exactly one set"); // RULE1

  property p_cell_entry;
    (r_q.st == bmsm_pkg::ST_RUN && conv_done_i && cell_low && !suppress && !shelf_go)
      |=> r_q.st == bmsm_pkg::ST_SS_SLEEP;
  endproperty
  a_cell_entry: assert property (p_cell_entry) else $error("cell trip did not enter sleep"); // RULE3

  property p_suppress;
    (r_q.st == bmsm_pkg::ST_RUN && suppress) |=> r_q.st != bmsm_pkg::ST_SS_SLEEP;
  endproperty
  a_suppress: assert property (p_suppress) else $error("entry not suppressed by charge"); // RULE4

  property p_force;
    (r_q.st == bmsm_pkg::ST_RUN && r_q.sample_sleep_request && !suppress && !shelf_go) |=> r_q.st == bmsm_pkg::ST_SS_SLEEP;
  endproperty
  a_force: assert property (p_force) else $error("request bit did not enter sleep"); // RULE5

  property p_dis_entry;
    (r_q.st == bmsm_pkg::ST_RUN && conv_done_i && dis_lo && !suppress && !shelf_go)
      |=> r_q.st == bmsm_pkg::ST_SS_SLEEP;
  endproperty
  a_dis_entry: assert property (p_dis_entry) else $error("current trip did not enter sleep"); // RULE6

  property p_interval;
    (r_q.st == bmsm_pkg::ST_RUN && r_d.st == bmsm_pkg::ST_SS_SLEEP) |=> r_q.slp_cnt == $past(intv);
  endproperty
  a_interval: assert property (p_interval) else $error("wrong wake interval loaded"); // RULE7

  property p_sample_sleep_request_exit;
    (r_q.st == bmsm_pkg::ST_SS_ACTIVE && sample_sleep_request_gone) |=> r_q.st == bmsm_pkg::ST_RUN && !conv_start_o;
  endproperty
  a_sample_sleep_request_exit: assert property (p_sample_sleep_request_exit) else $error("cleared request did not exit"); // RULE8

  property p_chg_wake;
    (r_q.st == bmsm_pkg::ST_SS_ACTIVE && conv_done_i && suppress)
      |=> r_q.st == bmsm_pkg::ST_RUN && r_q.irq_st[bmsm_pkg::IRQ_WAKE];
  endproperty
  a_chg_wake: assert property (p_chg_wake) else $error("charge did not wake"); // RULE9

  property p_vp_wake;
    (r_q.st == bmsm_pkg::ST_SS_ACTIVE && conv_done_i && vp_wake && !sample_sleep_request_gone) |=> r_q.st == bmsm_pkg::ST_RUN;
  endproperty
  a_vp_wake: assert property (p_vp_wake) else $error("pack voltage did not wake"); // RULE10

  property p_shelf_quiet;
    r_q.st == bmsm_pkg::ST_SHELF |-> !bus_en_o && !conv_start_o && !accum_en_o;
  endproperty
  a_shelf_quiet: assert property (p_shelf_quiet) else $error("activity in shelf"); // RULE11

  property p_shelf_entry;
    (r_q.st == bmsm_pkg::ST_RUN && shelf_go) |=> r_q.st == bmsm_pkg::ST_SHELF;
  endproperty
  a_shelf_entry: assert property (p_shelf_entry) else $error("armed shelf not entered"); // RULE13

  property p_shelf_exit;
    (r_q.st == bmsm_pkg::ST_SHELF && lp.high_done) |=> r_q.st == bmsm_pkg::ST_RUN && r_q.trip == '0 && !r_q.sample_sleep_request;
  endproperty
  a_shelf_exit: assert property (p_shelf_exit) else $error("shelf exit without reinit"); // RULE18

  property p_por;
    (r_q.st == bmsm_pkg::ST_POR && pack_voltage > POR_LEVEL) |=> r_q.st == bmsm_pkg::ST_RUN ##1 conv_start_o;
  endproperty
  a_por: assert property (p_por) else $error("no run after power-on"); // RULE15

endmodule : bmsm_sleep_ctrl

// [dv/bmsm_host_model.sv]
`timescale 1ns/1ps
module bmsm_host_model #(
  parameter int CONV_LAT = 5
) (
  input  wire logic clk_sys,    // System clock
  input  wire logic resetn,     // Async reset, active low
  input  wire logic conv_start, // Conversion set request
  input  wire logic hold_low,   // Master pulls both lines low
  output logic      conv_done,  // Conversion set finished
  output logic      scl,        // Bus clock line
  output logic      sda         // Bus data line
);
  int cnt;
  // ==========================================================================
  // Converter answers a fixed time after each start
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt       <= 0;
      conv_done <= 1'h0;
    end else begin
      conv_done <= (cnt == 1);
      if (conv_start) begin
        cnt <= CONV_LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
  // Open-drain lines, pull-up wins once released
  assign scl = !hold_low;
  assign sda = !hold_low;
endmodule : bmsm_host_model

// [dv/bmsm_sleep_ctrl_tb.sv]
`timescale 1ns/1ps
module bmsm_sleep_ctrl_tb;
  logic clk_sys, resetn, wr_i, rd_i, hold_low, conv_start_o, conv_done_i;
  logic scl_i, sda_i, analog_on_o, bus_en_o, irq_o, primary_osc_on_o, accum_en_o;
  logic [7:0] addr_i;
  logic [15:0] wdata_i, rdata_o, cell1, cell2, pack, rv;
  logic signed [15:0] cur;
  logic [2:0] mode_o;
  int error_cnt, n_compared, cyc, n_conv;
  // ==========================================================================
  // Instances
  bmsm_sleep_ctrl #(.LP_DIV(4), .HALF_LP(4), .SHELF_LP(3), .WAKE_LP(3)) dut (
    .clk_sys, .resetn, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .first_cell_input(cell1), .second_cell_input(cell2), .pack_voltage(pack),
    .current_i(cur), .conv_done_i, .scl_i, .sda_i, .conv_start_o, .analog_on_o,
    .primary_osc_on_o, .accum_en_o, .bus_en_o, .mode_o, .irq_o);
  bmsm_host_model hm (.clk_sys, .resetn, .conv_start(conv_start_o), .hold_low,
    .conv_done(conv_done_i), .scl(scl_i), .sda(sda_i));
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    n_conv += conv_start_o;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // Tasks
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr_i <= a; wdata_i <= d; wr_i <= 1'h1;
    @(posedge clk_sys);
    wr_i <= 1'h0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge clk_sys);
    addr_i <= a; rd_i <= 1'h1;
    @(posedge clk_sys);
    rd_i <= 1'h0;
    #1 rv = rdata_o;
  endtask : rd
  task wait_mode(input logic [2:0] m, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      #1;
      if (mode_o === m) break;
    end
    chk("mode", {13'h0, m}, {13'h0, mode_o});
  endtask : wait_mode
  task report_and_stop();
    if (error_cnt == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  // ==========================================================================
  // Main sequence
  initial begin
    resetn = 1'h0; wr_i = 1'h0; rd_i = 1'h0; addr_i = 8'h00; wdata_i = 16'h0000;
    hold_low = 1'h0; cell1 = 16'h0400; cell2 = 16'h0400; pack = 16'h0700; cur = 16'h0000;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'h1;
    repeat (5) @(posedge clk_sys);
    #1 chk("por_hold", 16'h0000, {13'h0, mode_o});
    pack <= 16'h0A00;
    wait_mode(3'h1, 20);
    n_conv = 0;
    repeat (50) @(posedge clk_sys);
    chk("run_conv", 16'h0001, {15'h0, n_conv > 2});
    rd(8'h3F); chk("unmapped", 16'h0000, rv);
    wr(bmsm_pkg::ADDR_IPOS, 16'h0010); wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0008);
    cur <= 16'h0020;
    wr(bmsm_pkg::ADDR_OPERATING_MODE_REG, 16'h0001);
    repeat (100) @(posedge clk_sys);
    rd(bmsm_pkg::ADDR_MODE); chk("suppressed", 16'h0001, rv);
    cur <= 16'h0000;
    wait_mode(3'h2, 200);
    chk("analog", 16'h0000, {13'h0, analog_on_o, primary_osc_on_o, accum_en_o});
    rd(bmsm_pkg::ADDR_IRQ_ST); chk("entry_irq", 16'h0001, {15'h0, rv[0]});
    wr(bmsm_pkg::ADDR_IRQ_EN, 16'h0001); rd(bmsm_pkg::ADDR_IRQ_EN);
    chk("irq_en", 16'h0001, rv);
    chk("irq_on", 16'h0001, {15'h0, irq_o});
    wr(bmsm_pkg::ADDR_IRQ_CLR, 16'h0001); rd(bmsm_pkg::ADDR_IRQ_ST);
    chk("irq_st", 16'h0000, rv);
    chk("irq_off", 16'h0000, {15'h0, irq_o});
    wr(bmsm_pkg::ADDR_OPERATING_MODE_REG, 16'h0000);
    wait_mode(3'h1, 40);
    chk("run_on", 16'h0007, {13'h0, analog_on_o, primary_osc_on_o, accum_en_o});
    wr(bmsm_pkg::ADDR_ADCCFG, 16'h0001);
    wr(bmsm_pkg::ADDR_OPERATING_MODE_REG, 16'h0003);
    wait_mode(3'h2, 200);
    repeat (40) @(posedge clk_sys);
    rd(bmsm_pkg::ADDR_MODE); chk("interval", 16'h0002, rv);
    wait_mode(3'h3, 30);
    cur <= 16'h0020;
    wait_mode(3'h1, 200);
    wr(bmsm_pkg::ADDR_OPERATING_MODE_REG, 16'h0000);
    wr(bmsm_pkg::ADDR_CELLTRIP, 16'h0100); wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0001);
    cell1 <= 16'h0080;
    wait_mode(3'h2, 200);
    cell1 <= 16'h0400;
    wr(bmsm_pkg::ADDR_SLEEP_WAKE_VOLTAGE_THRESHOLD, 16'h0900); wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0010);
    wait_mode(3'h1, 200);
    wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0002);
    cell2 <= 16'h0080;
    wait_mode(3'h2, 200);
    cell2 <= 16'h0400;
    wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0010);
    wait_mode(3'h1, 200);
    wr(bmsm_pkg::ADDR_INEG, 16'hFFF0); wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0004);
    cur <= 16'hFFE0;
    wait_mode(3'h2, 200);
    cur <= 16'h0000;
    wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0010);
    wait_mode(3'h1, 200);
    wr(bmsm_pkg::ADDR_TRIP_CONTROL, 16'h0020);
    hold_low <= 1'h1;
    repeat (4) @(posedge clk_sys);
    hold_low <= 1'h0;
    repeat (30) @(posedge clk_sys);
    rd(bmsm_pkg::ADDR_MODE); chk("short_low", 16'h0001, rv);
    hold_low <= 1'h1;
    wait_mode(3'h4, 100);
    chk("bus_en", 16'h0000, {15'h0, bus_en_o});
    rd(bmsm_pkg::ADDR_TRIP_CONTROL); chk("shelf_rd", 16'h0000, rv);
    hold_low <= 1'h0;
    wait_mode(3'h1, 100);
    rd(bmsm_pkg::ADDR_TRIP_CONTROL); chk("reinit", 16'h0000, rv);
    wr(bmsm_pkg::ADDR_PACK_VOLTAGE_THRESHOLD, 16'h0B00);
    hold_low <= 1'h1;
    wait_mode(3'h4, 100);
    hold_low <= 1'h0;
    wait_mode(3'h1, 100);
    rd(bmsm_pkg::ADDR_PACK_VOLTAGE_THRESHOLD); chk("reinit_vp", 16'h0000, rv);
    report_and_stop();
  end
endmodule : bmsm_sleep_ctrl_tb
